// ---- design/pdd_defs.vh ----
// Register indices, field positions and reset values of the power detector block.
`ifndef PDD_DEFS_VH
`define PDD_DEFS_VH

// ======================================================================
// Register indices (byte address is four times the index)
// ======================================================================
`define PDD_IDX_FILT_SEL   8'h0D
`define PDD_IDX_F0_UP_LO   8'h0F
`define PDD_IDX_F0_UP_HI   8'h10
`define PDD_IDX_F0_LW_LO   8'h11
`define PDD_IDX_F0_LW_HI   8'h12
`define PDD_IDX_IIR0_FMT   8'h13
`define PDD_IDX_F1_UP_LO   8'h16
`define PDD_IDX_F1_UP_HI   8'h17
`define PDD_IDX_F1_LW_LO   8'h18
`define PDD_IDX_F1_LW_HI   8'h19
`define PDD_IDX_IIR1_FMT   8'h1A
`define PDD_IDX_DWELL_LO   8'h1D
`define PDD_IDX_DWELL_HI   8'h1E
`define PDD_IDX_RMS_EN     8'h20
`define PDD_IDX_RMS_LEN    8'h21
`define PDD_IDX_PH_LO      8'h22
`define PDD_IDX_PH_HI      8'h23
`define PDD_IDX_PL_LO      8'h24
`define PDD_IDX_PL_HI      8'h25
`define PDD_IDX_RMS_FMT    8'h27
`define PDD_IDX_STATUS     8'h40
`define PDD_IDX_MASK       8'h41
`define PDD_IDX_AVG_LO     8'h42
`define PDD_IDX_AVG_HI     8'h43

// ======================================================================
// Fields and reset values
// ======================================================================
`define PDD_BIT_SEL        0
`define PDD_EXP_MSB        4
`define PDD_EXP_MAX        5'h10
`define PDD_RST_BYTE       8'h00
`define PDD_RST_WORD       16'h0000
`define PDD_RST_IRQ        5'h00
`define PDD_IRQ_W          5
`define PDD_IRQ_F0         0
`define PDD_IRQ_F1         1
`define PDD_IRQ_PH         2
`define PDD_IRQ_PL         3
`define PDD_IRQ_BLK        4
`define PDD_ADDR_W         12
`define PDD_SQ_SAT_HI      31
`define PDD_SQ_SAT_LO      30
`define PDD_SQ_MSB         29
`define PDD_SQ_LSB         14
`define PDD_PWR_MAX        16'hFFFF
`define PDD_ACC_W          33
`define PDD_CNT_W          17

`endif

// ---- design/pdd_dwell.v ----
// Peak flag with dwell-time hysteresis for one IIR filter output.
`include "pdd_defs.vh"

module pdd_dwell (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        ce,
   input  wire [15:0] level,
   input  wire [15:0] upper,
   input  wire [15:0] lower,
   input  wire [15:0] hold_count,
   output reg         flag,
   output reg         above_lower
);

   reg  [15:0] cnt;
   wire [16:0] next_cnt;
   wire        over_up;
   wire        under_lw;

   assign next_cnt = {1'b0, cnt} + 17'h00001;
   assign over_up  = $signed(level) >= $signed(upper);
   assign under_lw = $signed(level) < $signed(lower);

   // A dwell setting of zero still needs one cycle below the lower threshold.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag        <= 1'b0;
         cnt         <= `PDD_RST_WORD;
         above_lower <= 1'b0;
      end else if (ce) begin
         above_lower <= ~under_lw;
         if (over_up) begin
            flag <= 1'b1;                                  // see R02
            cnt  <= `PDD_RST_WORD;
         end else if (flag && under_lw) begin
            if (next_cnt >= {1'b0, hold_count}) begin      // see R03 R04
               flag <= 1'b0;
               cnt  <= `PDD_RST_WORD;
            end else begin
               cnt <= next_cnt[15:0];
            end
         end else begin
            cnt <= `PDD_RST_WORD;                          // see R03
         end
      end
   end

endmodule

// ---- design/pdd_top.v ----
// IIR peak dwell flags and RMS power detector with an APB register slave.
// ======================================================================
// How it works
// R01: Each IIR comparator output is 1-bit wide when its format bit is 0 and 2-bit when it is 1.
// R02: A filter's peak flag sets when its IIR output reaches that filter's upper threshold.
// R03: A set peak flag clears only after the output stays below the lower threshold for the dwell period.
// R04: The dwell period is a 16-bit count of clock cycles at the sample rate over eight.
// R05: The RMS power detector is idle when its enable bit is 0 and runs when it is 1.
// R06: Power is averaged over 2 to the power M clocks, with M from a 5-bit field of 0 to 16.
// R07: Each average power result is compared against a 16-bit high and a 16-bit low threshold.
// R08: One threshold LSB is one part in 2 to the 16 of full-scale power, as is the power result.
// R09: The RMS comparators output 1-bit format when their format bit is 0 and 2-bit when it is 1.
// R10: The IIR filter input is the high comparator alone or a three-level value from high and low.
// R11: Average power is the mean of squared samples per block, and outputs update once per block.
// R12: Software writes unused bits as zero and each 16-bit setting as low byte then high byte.
// ======================================================================
`include "pdd_defs.vh"

module pdd_top (
   input  wire                   CLK,
   input  wire                   RST_N,
   input  wire                   CE,
   input  wire                   PSEL,
   input  wire                   PENABLE,
   input  wire                   PWRITE,
   input  wire [`PDD_ADDR_W-1:0] PADDR,
   input  wire [31:0]            PWDATA,
   output reg  [31:0]            PRDATA,
   output reg                    PREADY,
   output reg                    PSLVERR,
   input  wire [15:0]            SAMPLE,
   input  wire                   HIGH_CMP,
   input  wire                   LOW_CMP,
   input  wire [15:0]            FILT0_LEVEL,
   input  wire [15:0]            FILT1_LEVEL,
   output reg  [1:0]             FILT_IN,
   output reg  [1:0]             FILT0_OUT,
   output reg  [1:0]             FILT1_OUT,
   output reg  [1:0]             POWER_OUT,
   output reg                    IRQ
);

   // ===================================================================
   // Configuration registers
   // ===================================================================
   reg                   filter_input_select;
   reg  [15:0]           filter0_upper_threshold;
   reg  [15:0]           filter0_lower_threshold;
   reg  [15:0]           filter1_upper_threshold;
   reg  [15:0]           filter1_lower_threshold;
   reg                   filter0_two_level_format;
   reg                   filter1_two_level_format;
   reg  [15:0]           filter_flag_hold_count;
   reg                   average_power_enable;
   reg  [4:0]            average_block_exponent;
   reg  [15:0]           power_upper_threshold;
   reg  [15:0]           power_lower_threshold;
   reg                   power_two_level_format;
   reg  [`PDD_IRQ_W-1:0] irq_status;
   reg  [`PDD_IRQ_W-1:0] irq_mask;
   reg  [15:0]           avg_power;

   wire [7:0]            idx;
   wire                  in_range;
   wire                  access;
   wire                  wr;
   wire [7:0]            wb;
   reg  [7:0]            rd_byte;
   reg                   rd_hit;

   assign idx      = PADDR[9:2];
   assign in_range = (PADDR[`PDD_ADDR_W-1:10] == 2'b00) && (PADDR[1:0] == 2'b00);
   assign access   = PSEL && PENABLE && !PREADY;
   assign wr       = access && PWRITE && in_range && rd_hit;
   assign wb       = PWDATA[7:0];

   // ===================================================================
   // Read decode
   // ===================================================================
   always @* begin
      rd_byte = `PDD_RST_BYTE;
      rd_hit  = 1'b1;
      if (idx == `PDD_IDX_FILT_SEL)
         rd_byte = {7'h00, filter_input_select};
      else if (idx == `PDD_IDX_F0_UP_LO)
         rd_byte = filter0_upper_threshold[7:0];
      else if (idx == `PDD_IDX_F0_UP_HI)
         rd_byte = filter0_upper_threshold[15:8];
      else if (idx == `PDD_IDX_F0_LW_LO)
         rd_byte = filter0_lower_threshold[7:0];
      else if (idx == `PDD_IDX_F0_LW_HI)
         rd_byte = filter0_lower_threshold[15:8];
      else if (idx == `PDD_IDX_IIR0_FMT)
         rd_byte = {7'h00, filter0_two_level_format};
      else if (idx == `PDD_IDX_F1_UP_LO)
         rd_byte = filter1_upper_threshold[7:0];
      else if (idx == `PDD_IDX_F1_UP_HI)
         rd_byte = filter1_upper_threshold[15:8];
      else if (idx == `PDD_IDX_F1_LW_LO)
         rd_byte = filter1_lower_threshold[7:0];
      else if (idx == `PDD_IDX_F1_LW_HI)
         rd_byte = filter1_lower_threshold[15:8];
      else if (idx == `PDD_IDX_IIR1_FMT)
         rd_byte = {7'h00, filter1_two_level_format};
      else if (idx == `PDD_IDX_DWELL_LO)
         rd_byte = filter_flag_hold_count[7:0];
      else if (idx == `PDD_IDX_DWELL_HI)
         rd_byte = filter_flag_hold_count[15:8];
      else if (idx == `PDD_IDX_RMS_EN)
         rd_byte = {7'h00, average_power_enable};
      else if (idx == `PDD_IDX_RMS_LEN)
         rd_byte = {3'h0, average_block_exponent};
      else if (idx == `PDD_IDX_PH_LO)
         rd_byte = power_upper_threshold[7:0];
      else if (idx == `PDD_IDX_PH_HI)
         rd_byte = power_upper_threshold[15:8];
      else if (idx == `PDD_IDX_PL_LO)
         rd_byte = power_lower_threshold[7:0];
      else if (idx == `PDD_IDX_PL_HI)
         rd_byte = power_lower_threshold[15:8];
      else if (idx == `PDD_IDX_RMS_FMT)
         rd_byte = {7'h00, power_two_level_format};
      else if (idx == `PDD_IDX_STATUS)
         rd_byte = {3'h0, irq_status};
      else if (idx == `PDD_IDX_MASK)
         rd_byte = {3'h0, irq_mask};
      else if (idx == `PDD_IDX_AVG_LO)
         rd_byte = avg_power[7:0];
      else if (idx == `PDD_IDX_AVG_HI)
         rd_byte = avg_power[15:8];
      else
         rd_hit = 1'b0;
   end

   // ===================================================================
   // APB slave: one wait state, unmapped addresses answer with an error
   // ===================================================================
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h00000000;
      end else if (CE) begin
         PREADY  <= access;
         PSLVERR <= access && !(in_range && rd_hit);
         if (access && !PWRITE)
            PRDATA <= (in_range && rd_hit) ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

   // Wide settings are written one byte lane at a time, low byte first.
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         filter_input_select      <= 1'b0;
         filter0_upper_threshold  <= `PDD_RST_WORD;
         filter0_lower_threshold  <= `PDD_RST_WORD;
         filter1_upper_threshold  <= `PDD_RST_WORD;
         filter1_lower_threshold  <= `PDD_RST_WORD;
         filter0_two_level_format <= 1'b0;
         filter1_two_level_format <= 1'b0;
         filter_flag_hold_count   <= `PDD_RST_WORD;
         average_power_enable     <= 1'b0;
         average_block_exponent   <= 5'h00;
         power_upper_threshold    <= `PDD_RST_WORD;
         power_lower_threshold    <= `PDD_RST_WORD;
         power_two_level_format   <= 1'b0;
         irq_mask                 <= `PDD_RST_IRQ;
      end else if (CE && wr) begin
         if (idx == `PDD_IDX_FILT_SEL)
            filter_input_select <= wb[`PDD_BIT_SEL];
         else if (idx == `PDD_IDX_F0_UP_LO)
            filter0_upper_threshold[7:0] <= wb;                       // see R12
         else if (idx == `PDD_IDX_F0_UP_HI)
            filter0_upper_threshold[15:8] <= wb;
         else if (idx == `PDD_IDX_F0_LW_LO)
            filter0_lower_threshold[7:0] <= wb;
         else if (idx == `PDD_IDX_F0_LW_HI)
            filter0_lower_threshold[15:8] <= wb;
         else if (idx == `PDD_IDX_IIR0_FMT)
            filter0_two_level_format <= wb[`PDD_BIT_SEL];
         else if (idx == `PDD_IDX_F1_UP_LO)
            filter1_upper_threshold[7:0] <= wb;
         else if (idx == `PDD_IDX_F1_UP_HI)
            filter1_upper_threshold[15:8] <= wb;
         else if (idx == `PDD_IDX_F1_LW_LO)
            filter1_lower_threshold[7:0] <= wb;
         else if (idx == `PDD_IDX_F1_LW_HI)
            filter1_lower_threshold[15:8] <= wb;
         else if (idx == `PDD_IDX_IIR1_FMT)
            filter1_two_level_format <= wb[`PDD_BIT_SEL];
         else if (idx == `PDD_IDX_DWELL_LO)
            filter_flag_hold_count[7:0] <= wb;                        // see R04
         else if (idx == `PDD_IDX_DWELL_HI)
            filter_flag_hold_count[15:8] <= wb;
         else if (idx == `PDD_IDX_RMS_EN)
            average_power_enable <= wb[`PDD_BIT_SEL];
         else if (idx == `PDD_IDX_RMS_LEN)
            average_block_exponent <= (wb[`PDD_EXP_MSB:0] > `PDD_EXP_MAX) ?
                                      `PDD_EXP_MAX : wb[`PDD_EXP_MSB:0];  // see R06
         else if (idx == `PDD_IDX_PH_LO)
            power_upper_threshold[7:0] <= wb;
         else if (idx == `PDD_IDX_PH_HI)
            power_upper_threshold[15:8] <= wb;
         else if (idx == `PDD_IDX_PL_LO)
            power_lower_threshold[7:0] <= wb;
         else if (idx == `PDD_IDX_PL_HI)
            power_lower_threshold[15:8] <= wb;
         else if (idx == `PDD_IDX_RMS_FMT)
            power_two_level_format <= wb[`PDD_BIT_SEL];
         else if (idx == `PDD_IDX_MASK)
            irq_mask <= wb[`PDD_IRQ_W-1:0];
      end
   end

   // ===================================================================
   // IIR filter input and peak flags
   // ===================================================================
   wire [15:0] lvl  [0:1];
   wire [15:0] upth [0:1];
   wire [15:0] lwth [0:1];
   wire [1:0]  pk_flag;
   wire [1:0]  pk_above;
   reg  [1:0]  pk_flag_d;

   assign lvl[0]  = FILT0_LEVEL;
   assign lvl[1]  = FILT1_LEVEL;
   assign upth[0] = filter0_upper_threshold;
   assign upth[1] = filter1_upper_threshold;
   assign lwth[0] = filter0_lower_threshold;
   assign lwth[1] = filter1_lower_threshold;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gen_filt
         pdd_dwell u_dwell (
            .clk         (CLK),
            .rst_n       (RST_N),
            .ce          (CE),
            .level       (lvl[g]),
            .upper       (upth[g]),
            .lower       (lwth[g]),
            .hold_count  (filter_flag_hold_count),
            .flag        (pk_flag[g]),
            .above_lower (pk_above[g])
         );
      end
   endgenerate

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         FILT_IN   <= 2'b00;
         FILT0_OUT <= 2'b00;
         FILT1_OUT <= 2'b00;
         pk_flag_d <= 2'b00;
      end else if (CE) begin
         pk_flag_d <= pk_flag;
         // Three-level value in two's complement: 01 is +1, 11 is -1.
         if (!filter_input_select)
            FILT_IN <= {1'b0, HIGH_CMP};                             // see R10
         else if (HIGH_CMP)
            FILT_IN <= 2'b01;
         else if (LOW_CMP)
            FILT_IN <= 2'b11;
         else
            FILT_IN <= 2'b00;
         FILT0_OUT <= filter0_two_level_format ? {pk_flag[0], pk_above[0]}
                                               : {1'b0, pk_flag[0]};   // see R01
         FILT1_OUT <= filter1_two_level_format ? {pk_flag[1], pk_above[1]}
                                               : {1'b0, pk_flag[1]};
      end
   end

   // ===================================================================
   // RMS power detector
   // ===================================================================
   reg  [`PDD_ACC_W-1:0] acc;
   reg  [`PDD_CNT_W-1:0] blk_cnt;
   reg                   blk_done;
   wire [31:0]           sq;
   wire [15:0]           pw;
   wire [`PDD_ACC_W-1:0] next_acc;
   wire [`PDD_ACC_W-1:0] shifted;
   wire [`PDD_CNT_W-1:0] blk_last;
   wire [15:0]           next_avg;

   assign sq       = $signed(SAMPLE) * $signed(SAMPLE);
   assign pw       = (sq[`PDD_SQ_SAT_HI:`PDD_SQ_SAT_LO] != 2'b00) ? `PDD_PWR_MAX
                                                                  : sq[`PDD_SQ_MSB:`PDD_SQ_LSB]; // see R08
   assign next_acc = acc + {17'h00000, pw};
   assign shifted  = next_acc >> average_block_exponent;
   assign next_avg = shifted[15:0];
   assign blk_last = ({{(`PDD_CNT_W-1){1'b0}}, 1'b1} << average_block_exponent) - 17'h00001;

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         acc       <= {`PDD_ACC_W{1'b0}};
         blk_cnt   <= {`PDD_CNT_W{1'b0}};
         blk_done  <= 1'b0;
         avg_power <= `PDD_RST_WORD;
         POWER_OUT <= 2'b00;
      end else if (CE) begin
         blk_done <= 1'b0;
         if (!average_power_enable) begin                            // see R05
            acc       <= {`PDD_ACC_W{1'b0}};
            blk_cnt   <= {`PDD_CNT_W{1'b0}};
            POWER_OUT <= 2'b00;
         end else if (blk_cnt >= blk_last) begin                     // see R06 R11
            acc       <= {`PDD_ACC_W{1'b0}};
            blk_cnt   <= {`PDD_CNT_W{1'b0}};
            blk_done  <= 1'b1;
            avg_power <= next_avg;
            if (power_two_level_format)                              // see R09
               POWER_OUT <= {next_avg > power_upper_threshold,
                             next_avg >= power_lower_threshold};     // see R07
            else
               POWER_OUT <= {1'b0, next_avg > power_upper_threshold};
         end else begin
            acc     <= next_acc;
            blk_cnt <= blk_cnt + 17'h00001;
         end
      end
   end

   // ===================================================================
   // Interrupt status, write one to clear, a new event wins over a clear
   // ===================================================================
   wire [`PDD_IRQ_W-1:0] ev;
   wire [`PDD_IRQ_W-1:0] clr;

   assign ev[`PDD_IRQ_F0]  = pk_flag[0] && !pk_flag_d[0];
   assign ev[`PDD_IRQ_F1]  = pk_flag[1] && !pk_flag_d[1];
   assign ev[`PDD_IRQ_PH]  = blk_done && (avg_power > power_upper_threshold);
   assign ev[`PDD_IRQ_PL]  = blk_done && (avg_power < power_lower_threshold);
   assign ev[`PDD_IRQ_BLK] = blk_done;
   assign clr = (wr && idx == `PDD_IDX_STATUS) ? wb[`PDD_IRQ_W-1:0] : `PDD_RST_IRQ;

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_status <= `PDD_RST_IRQ;
         IRQ        <= 1'b0;
      end else if (CE) begin
         irq_status <= (irq_status & ~clr) | ev;
         IRQ        <= |(((irq_status & ~clr) | ev) & irq_mask);
      end
   end

endmodule

// ---- testbench/pdd_top_assertions.sv ----
// Port-level assertions for the power detector top.
`include "pdd_defs.vh"
module pdd_top_chk (
   input wire                   CLK,
   input wire                   RST_N,
   input wire                   CE,
   input wire                   PSEL,
   input wire                   PENABLE,
   input wire                   PWRITE,
   input wire [`PDD_ADDR_W-1:0] PADDR,
   input wire [31:0]            PRDATA,
   input wire                   PREADY,
   input wire                   PSLVERR,
   input wire                   HIGH_CMP,
   input wire                   LOW_CMP,
   input wire [1:0]             FILT_IN
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] live;
   wire        acc = PSEL && PENABLE && !PREADY && CE;
   // Outputs are held at zero for one edge after reset, so checks wait two edges.
   always_ff @(posedge CLK or negedge RST_N)
      live <= !RST_N ? 2'b00 : {live[0], 1'b1};
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   ready_pulse_a: assert property (PREADY && CE |=> !PREADY)
      else $error("ready too long");
   ready_after_a: assert property (live[1] && acc |=> PREADY)
      else $error("ready late");
   ready_cause_a: assert property ($rose(PREADY) |-> $past(acc))
      else $error("ready without an access phase");
   err_with_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error flag without ready");
   misalign_err_a: assert property (live[1] && acc && PADDR[1:0] != 2'b00 |=> PSLVERR)
      else $error("misaligned access not refused");
   rdata_upper_a: assert property (PRDATA[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   rdata_hold_a: assert property (!(acc && !PWRITE) |=> $stable(PRDATA))
      else $error("read data changed outside a read");
   filt_high_a: assert property (live[1] && CE && HIGH_CMP |=> FILT_IN == 2'b01)
      else $error("filter input not plus one");
   filt_idle_a: assert property (live[1] && CE && !HIGH_CMP && !LOW_CMP |=> FILT_IN == 2'b00)
      else $error("filter input not zero");
endmodule

bind pdd_top pdd_top_chk u_chk (.CLK, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA,
                                .PREADY, .PSLVERR, .HIGH_CMP, .LOW_CMP, .FILT_IN);

// ---- testbench/pdd_host.sv ----
// APB master model of the host register programmer.
`include "pdd_defs.vh"
module pdd_host (
   input  wire logic              CLK,
   input  wire logic              PREADY,
   input  wire logic              PSLVERR,
   input  wire logic [31:0]       PRDATA,
   output logic                   PSEL,
   output logic                   PENABLE,
   output logic                   PWRITE,
   output logic [`PDD_ADDR_W-1:0] PADDR,
   output logic [31:0]            PWDATA
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 0;
   task automatic xfer(input logic w, input logic [`PDD_ADDR_W-1:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic e);
      int n;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= {24'h000000, d};
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 64);
      q = PRDATA[7:0];
      e = (n == 64) ? 1'bx : PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      PADDR <= ~a;
      PWDATA <= ~{24'h000000, d};
   endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench comparing the power detector with a reference model.
`include "pdd_defs.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ======================================================================
   // Signals and reference state
   localparam logic signed [15:0] up_th = 16'sh1000, lw_th = 16'sh0800;
   logic CLK, RST_N = 1'b0, CE = 1'b1, HIGH_CMP = 1'b0, LOW_CMP = 1'b0;
   logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, e;
   logic sel = 1'b0, en = 1'b0, chk_on = 1'b0;
   logic [`PDD_ADDR_W-1:0] PADDR;
   logic [31:0] PWDATA, PRDATA;
   logic [15:0] SAMPLE = 16'h0000, FILT0_LEVEL = 16'h0000, FILT1_LEVEL = 16'h0000, ph, pl, p;
   logic [7:0] q, x, regs [11] = '{8'h13, 8'h1A, 8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h27};
   logic [1:0] FILT_IN, FILT0_OUT, FILT1_OUT, POWER_OUT, fmt = 2'b00, fin_r, po_r, fo_r [2];
   logic [1:0] fl = 2'b00, ab = 2'b00;
   logic signed [15:0] lv, lvl [12] = '{16'h2000, 16'h1000, 16'h0C00, 16'h0800, 16'h07FF, 16'h0000,
                                       16'hF000, 16'h8000, 16'h0100, 16'h0000, 16'h0400, 16'h0000};
   int failures = 0, n_tests = 0, cyc = 0, dw = 0, cnt [2] = '{0, 0};

   pdd_top uut (.CLK, .RST_N, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
                .SAMPLE, .HIGH_CMP, .LOW_CMP, .FILT0_LEVEL, .FILT1_LEVEL, .FILT_IN, .FILT0_OUT,
                .FILT1_OUT, .POWER_OUT, .IRQ);
   pdd_host host (.CLK, .PREADY, .PSLVERR, .PRDATA, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA);

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   // ======================================================================
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (failures == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      host.xfer(1'b1, {2'b00, i, 2'b00}, d, q, e);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] exp);
      host.xfer(1'b0, {2'b00, i, 2'b00}, 8'h00, q, e);
      chk({e, q}, {1'b0, exp});
   endtask
   task automatic wr16(input logic [7:0] i, input logic [15:0] v);
      wr(i, v[7:0]);
      wr(i + 8'h01, v[15:8]);
   endtask
   task automatic settle();
      repeat (2) @(posedge CLK);
      @(negedge CLK);
   endtask
   function automatic logic [15:0] pw(input logic signed [15:0] s);
      logic [31:0] sq;
      sq = s * s;
      return (sq >= 32'h40000000) ? 16'hFFFF : sq[29:14];
   endfunction
   task automatic cfg(input logic f, input int d);
      sel = f;
      fmt = {!f, f};
      dw = d;
      en = 1'b1;
      ph = 16'($urandom);
      pl = 16'($urandom);
      wr(`PDD_IDX_FILT_SEL, {7'h00, f});
      wr(`PDD_IDX_IIR0_FMT, {7'h00, f});
      wr(`PDD_IDX_IIR1_FMT, {7'h00, !f});
      wr(`PDD_IDX_RMS_FMT, {7'h00, f});
      wr16(`PDD_IDX_DWELL_LO, 16'(d));
      wr16(`PDD_IDX_F0_UP_LO, up_th);
      wr16(`PDD_IDX_F0_LW_LO, lw_th);
      wr16(`PDD_IDX_F1_UP_LO, up_th);
      wr16(`PDD_IDX_F1_LW_LO, lw_th);
      wr16(`PDD_IDX_PH_LO, ph);
      wr16(`PDD_IDX_PL_LO, pl);
      wr(`PDD_IDX_RMS_LEN, 8'h00);
      wr(`PDD_IDX_RMS_EN, 8'h01);
      repeat (12) @(posedge CLK);
   endtask
   // ======================================================================
   // Reference model and checks
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         give_verdict();
      end
      fin_r <= sel ? (HIGH_CMP ? 2'b01 : LOW_CMP ? 2'b11 : 2'b00) : {1'b0, HIGH_CMP};
      for (int i = 0; i < 2; i++) begin
         lv = i ? FILT1_LEVEL : FILT0_LEVEL;
         fo_r[i] <= fmt[i] ? {fl[i], ab[i]} : {1'b0, fl[i]};
         ab[i] <= lv >= lw_th;
         if (lv >= up_th) begin
            fl[i] <= 1'b1;
            cnt[i] <= 0;
         end else if (lv >= lw_th || !fl[i]) begin
            cnt[i] <= 0;
         end else if (cnt[i] + 1 >= (dw > 0 ? dw : 1)) begin
            fl[i] <= 1'b0;
            cnt[i] <= 0;
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
      end
      p = pw(SAMPLE);
      po_r <= !en ? 2'b00 : sel ? {p > ph, p >= pl} : {1'b0, p > ph};
   end
   always @(negedge CLK) begin
      if (chk_on) begin
         chk(FILT_IN, fin_r);
         chk(FILT0_OUT, fo_r[0]);
         chk(FILT1_OUT, fo_r[1]);
         chk(POWER_OUT, po_r);
      end
   end
   // ======================================================================
   // Main sequence
   initial begin
      void'($urandom(82));
      repeat (20) @(posedge CLK);
      RST_N <= 1'b1;
      foreach (regs[k])
         rd(regs[k], 8'h00);
      foreach (regs[k]) begin
         x = 8'($urandom);
         if (regs[k] inside {8'h13, 8'h1A, 8'h20, 8'h27})
            x = x & 8'h01;
         if (regs[k] == 8'h21)
            x = 8'($urandom_range(16, 0));
         wr(regs[k], x);
         rd(regs[k], x);
      end
      wr(`PDD_IDX_RMS_LEN, 8'h11);
      rd(`PDD_IDX_RMS_LEN, 8'h10);
      host.xfer(1'b0, 12'h0FC, 8'h00, q, e);
      chk({e, q}, 9'h100);
      host.xfer(1'b1, 12'h081, 8'h00, q, e);
      chk(e, 1'b1);
      for (int k = 0; k < 2; k++) begin
         cfg(k[0], k * 5);
         chk_on = 1'b1;
         repeat (200) begin
            @(posedge CLK);
            HIGH_CMP <= 1'($urandom);
            LOW_CMP <= 1'($urandom);
            SAMPLE <= ($urandom % 16 == 0) ? 16'h8000 : 16'($urandom);
            FILT0_LEVEL <= lvl[$urandom % 12];
            FILT1_LEVEL <= lvl[$urandom % 12];
         end
         chk_on = 1'b0;
         {FILT0_LEVEL, FILT1_LEVEL} <= '0;
      end
      wr16(`PDD_IDX_PH_LO, 16'h3FFF);
      wr16(`PDD_IDX_PL_LO, 16'h4001);
      wr(`PDD_IDX_RMS_LEN, 8'h02);
      SAMPLE <= 16'hC000;
      repeat (20) @(posedge CLK);
      @(negedge CLK);
      chk(POWER_OUT, 2'b10);
      rd(`PDD_IDX_AVG_LO, 8'h00);
      rd(`PDD_IDX_AVG_HI, 8'h40);
      wr(`PDD_IDX_RMS_EN, 8'h00);
      settle();
      chk(POWER_OUT, 2'b00);
      wr(`PDD_IDX_MASK, 8'h1F);
      wr(`PDD_IDX_STATUS, 8'h1F);
      rd(`PDD_IDX_STATUS, 8'h00);
      settle();
      chk(IRQ, 1'b0);
      @(posedge CLK);
      FILT0_LEVEL <= 16'h2000;
      @(posedge CLK);
      FILT0_LEVEL <= 16'h0000;
      settle();
      chk(IRQ, 1'b1);
      rd(`PDD_IDX_STATUS, 8'h01);
      wr(`PDD_IDX_MASK, 8'h1E);
      settle();
      chk(IRQ, 1'b0);
      wr(`PDD_IDX_MASK, 8'h1F);
      settle();
      chk(IRQ, 1'b1);
      wr(`PDD_IDX_STATUS, 8'h01);
      settle();
      chk(IRQ, 1'b0);
      give_verdict();
   end
endmodule
